// ---- core/sic_pkg.sv ----
/*
 Constants shared by the six-source interrupt controller: register
 addresses, bit positions, reset values and vector layout.
 Assumes a single core clock domain and an 8-bit register port.
*/
package sic_pkg;

   // Register addresses on the special-function port.
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
   localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
   localparam logic [7:0] ADDR_ENABLE_MASK = 8'ha8;
   localparam logic [7:0] ADDR_PRIORITY = 8'hb8;
   localparam logic [7:0] ADDR_TIMER2_CONTROL = 8'hc8;

   // Bit positions in the timer control register.
   localparam int TCR_TF1 = 7;
   localparam int TCR_TF0 = 5;
   localparam int TCR_IE1 = 3;
   localparam int TCR_IT1 = 2;
   localparam int TCR_IE0 = 1;
   localparam int TCR_IT0 = 0;

   // Bit positions in the serial control register.
   localparam int SCR_RX = 0;
   localparam int SCR_TX = 1;

   // Bit positions in the Timer 2 control register.
   localparam int T2C_TF2 = 7;
   localparam int T2C_TIMER2_EXTERNAL_FLAG = 6;
   localparam int T2C_TIMER2_EXTERNAL_ENABLE = 3;

   // Global enable bit and the reserved bit of the enable register.
   localparam int IEM_GLOBAL = 7;
   localparam int IEM_RSVD = 6;

   // Source indices, also the fixed order within a level.
   localparam int SRC_EXT0 = 0;
   localparam int SRC_TMR0 = 1;
   localparam int SRC_EXT1 = 2;
   localparam int SRC_TMR1 = 3;
   localparam int SRC_SER = 4;
   localparam int SRC_TMR2 = 5;
   localparam int NUM_SRC = 6;

   // Vector of source n is VEC_BASE plus n times eight.
   localparam logic [15:0] VEC_BASE = 16'h0003;

   // Reset values.
   localparam logic [7:0] RST_ENABLE_MASK = 8'h00;
   localparam logic [5:0] RST_PRIORITY = 6'h00;
   localparam logic [2:0] RST_PIN_LEVEL = 3'h7;

endpackage : sic_pkg

// ---- core/sic_ctrl.sv ----
/*
 Two-level interrupt controller with six sources, its register port
 and the handshake toward the core's vectoring logic.
 Assumes core_clk is the machine clock, mc_tick marks one cycle per
 machine cycle, and the core pulses vec_ack and reti_done.
*/
module sic_ctrl
   import sic_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // External pins, asynchronous to the core clock.
   input wire logic ext_irq0_pin,
   input wire logic ext_irq1_pin,
   input wire logic timer2_trigger_pin,
   // Set pulses from the timers and the serial port.
   input wire logic timer0_overflow,
   input wire logic timer1_overflow,
   input wire logic timer2_overflow,
   input wire logic rx_done,
   input wire logic tx_done,
   // Register port.
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // Core handshake.
   input wire logic mc_tick,
   input wire logic insn_boundary,
   input wire logic vec_ack,
   input wire logic reti_done,
   output logic irq_req,
   output logic [15:0] irq_vector,
   output logic wake_req
);

   // Whole state of the block in one record.
   typedef struct packed {
      logic [2:0] pin_meta;
      logic [2:0] pin_sync;
      logic [2:0] pin_prev;
      logic [7:0] enable_mask;
      logic [5:0] priority_sel;
      logic irq0_type_select;
      logic irq1_type_select;
      logic irq0_request_flag;
      logic irq1_request_flag;
      logic timer0_overflow_flag;
      logic timer1_overflow_flag;
      logic rx_done_flag;
      logic tx_done_flag;
      logic timer2_overflow_flag;
      logic timer2_external_flag;
      logic timer2_external_enable;
      logic active_hi;
      logic active_lo;
      logic req;
      logic req_hi;
      logic [2:0] req_idx;
      logic [15:0] vec;
      logic [7:0] rdata;
      logic wake;
   } sic_state_s;

   sic_state_s state_r;   // Registered state.
   sic_state_s state_nxt; // Next state.

   // Lowest set index wins; returns {found, index}.
   function automatic logic [3:0] sic_pick(input logic [5:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction : sic_pick

   // Next-state logic for every field.
   always_comb begin
      logic [5:0] raw;
      logic [5:0] pend;
      logic [5:0] hi;
      logic [5:0] lo;
      logic [3:0] pick_hi;
      logic [3:0] pick_lo;
      logic [2:0] fall;
      logic wr_tcr;
      logic wr_scr;
      logic wr_t2c;
      raw = 6'h00;
      pend = 6'h00;
      hi = 6'h00;
      lo = 6'h00;
      pick_hi = 4'h0;
      pick_lo = 4'h0;
      fall = 3'h0;
      wr_tcr = sfr_wr && (sfr_addr == ADDR_TIMER_CONTROL);
      wr_scr = sfr_wr && (sfr_addr == ADDR_SERIAL_CONTROL);
      wr_t2c = sfr_wr && (sfr_addr == ADDR_TIMER2_CONTROL);
      state_nxt = state_r;

      // Three flops on each pin; only the second and third stages are looked at.
      state_nxt.pin_meta = {timer2_trigger_pin, ext_irq1_pin, ext_irq0_pin};
      state_nxt.pin_sync = state_r.pin_meta;
      state_nxt.pin_prev = state_r.pin_sync;
      fall = state_r.pin_prev & ~state_r.pin_sync;

      // Software writes to the enable and priority registers.
      if (sfr_wr && (sfr_addr == ADDR_ENABLE_MASK)) begin
         state_nxt.enable_mask = sfr_wdata;
         state_nxt.enable_mask[IEM_RSVD] = 1'b0;
      end
      if (sfr_wr && (sfr_addr == ADDR_PRIORITY)) begin
         state_nxt.priority_sel = sfr_wdata[5:0];
      end

      // Software writes to flags come first so hardware sets win.
      if (wr_tcr) begin
         state_nxt.irq0_type_select = sfr_wdata[TCR_IT0];
         state_nxt.irq1_type_select = sfr_wdata[TCR_IT1];
         state_nxt.irq0_request_flag = sfr_wdata[TCR_IE0];
         state_nxt.irq1_request_flag = sfr_wdata[TCR_IE1];
         state_nxt.timer0_overflow_flag = sfr_wdata[TCR_TF0];
         state_nxt.timer1_overflow_flag = sfr_wdata[TCR_TF1];
      end
      if (wr_scr) begin
         state_nxt.rx_done_flag = sfr_wdata[SCR_RX];
         state_nxt.tx_done_flag = sfr_wdata[SCR_TX];
      end
      if (wr_t2c) begin
         state_nxt.timer2_overflow_flag = sfr_wdata[T2C_TF2];
         state_nxt.timer2_external_flag = sfr_wdata[T2C_TIMER2_EXTERNAL_FLAG];
         state_nxt.timer2_external_enable = sfr_wdata[T2C_TIMER2_EXTERNAL_ENABLE];
      end

      // Vectoring clears only the flags that hardware may clear.
      if (vec_ack && state_r.req) begin
         case (state_r.req_idx)
            3'(SRC_EXT0): begin
               if (state_r.irq0_type_select) begin
                  state_nxt.irq0_request_flag = 1'b0;
               end
            end
            3'(SRC_TMR0): begin
               state_nxt.timer0_overflow_flag = 1'b0;
            end
            3'(SRC_EXT1): begin
               if (state_r.irq1_type_select) begin
                  state_nxt.irq1_request_flag = 1'b0;
               end
            end
            3'(SRC_TMR1): begin
               state_nxt.timer1_overflow_flag = 1'b0;
            end
            default: begin
               // Serial and Timer 2 flags are left to software.
               state_nxt.req = 1'b0;
            end
         endcase
         state_nxt.req = 1'b0;
         // Mark the level now in service.
         if (state_r.req_hi) begin
            state_nxt.active_hi = 1'b1;
         end else begin
            state_nxt.active_lo = 1'b1;
         end
      end else if (reti_done) begin
         // Return ends the highest level in service.
         if (state_r.active_hi) begin
            state_nxt.active_hi = 1'b0;
         end else begin
            state_nxt.active_lo = 1'b0;
         end
      end

      // External pins: edge mode sets, level mode follows the pin.
      if (state_nxt.irq0_type_select) begin
         state_nxt.irq0_request_flag = state_nxt.irq0_request_flag | fall[0];
      end else begin
         // Level flag mirrors the low pin, so vectoring and software writes never clear it.
         state_nxt.irq0_request_flag = ~state_r.pin_sync[0];
      end
      if (state_nxt.irq1_type_select) begin
         state_nxt.irq1_request_flag = state_nxt.irq1_request_flag | fall[1];
      end else begin
         state_nxt.irq1_request_flag = ~state_r.pin_sync[1];
      end

      // Timer and serial set pulses win over any clear this cycle.
      state_nxt.timer0_overflow_flag = state_nxt.timer0_overflow_flag | timer0_overflow;
      state_nxt.timer1_overflow_flag = state_nxt.timer1_overflow_flag | timer1_overflow;
      state_nxt.rx_done_flag = state_nxt.rx_done_flag | rx_done;
      state_nxt.tx_done_flag = state_nxt.tx_done_flag | tx_done;
      state_nxt.timer2_overflow_flag = state_nxt.timer2_overflow_flag | timer2_overflow;

      // The trigger pin acts whatever Timer 2 itself is doing.
      if (state_r.timer2_external_enable && fall[2]) begin
         state_nxt.timer2_external_flag = 1'b1;
      end

      // Gather requests from the flags, never from the pins.
      raw[SRC_EXT0] = state_r.irq0_request_flag;
      raw[SRC_TMR0] = state_r.timer0_overflow_flag;
      raw[SRC_EXT1] = state_r.irq1_request_flag;
      raw[SRC_TMR1] = state_r.timer1_overflow_flag;
      raw[SRC_SER] = state_r.rx_done_flag | state_r.tx_done_flag;
      raw[SRC_TMR2] = state_r.timer2_overflow_flag | state_r.timer2_external_flag;

      // Individual and global enables.
      pend = raw & state_r.enable_mask[5:0];
      if (!state_r.enable_mask[IEM_GLOBAL]) begin
         pend = 6'h00;
      end

      // Split by level; a level in service blocks its own and lower.
      hi = pend & state_r.priority_sel;
      lo = pend & ~state_r.priority_sel;
      if (state_r.active_hi) begin
         hi = 6'h00;
         lo = 6'h00;
      end
      if (state_r.active_lo) begin
         lo = 6'h00;
      end
      pick_hi = sic_pick(hi);
      pick_lo = sic_pick(lo);

      // Sample once per machine cycle, post only at a boundary.
      if (mc_tick && insn_boundary && !state_r.req && !vec_ack) begin
         if (pick_hi[3]) begin
            state_nxt.req = 1'b1;
            state_nxt.req_hi = 1'b1;
            state_nxt.req_idx = pick_hi[2:0];
         end else if (pick_lo[3]) begin
            state_nxt.req = 1'b1;
            state_nxt.req_hi = 1'b0;
            state_nxt.req_idx = pick_lo[2:0];
         end
      end
      state_nxt.vec = 16'(VEC_BASE + {10'h000, state_nxt.req_idx, 3'h0});

      // Power-down wake from either external pin; clock keeps running.
      state_nxt.wake = state_r.enable_mask[IEM_GLOBAL]
         & ((state_r.irq0_request_flag & state_r.enable_mask[SRC_EXT0])
         | (state_r.irq1_request_flag & state_r.enable_mask[SRC_EXT1]));

      // Read data, registered; unknown addresses read zero.
      state_nxt.rdata = 8'h00;
      if (sfr_rd) begin
         case (sfr_addr)
            ADDR_ENABLE_MASK: begin
               state_nxt.rdata = state_r.enable_mask;
            end
            ADDR_PRIORITY: begin
               state_nxt.rdata = {2'h0, state_r.priority_sel};
            end
            ADDR_TIMER_CONTROL: begin
               state_nxt.rdata[TCR_TF1] = state_r.timer1_overflow_flag;
               state_nxt.rdata[TCR_TF0] = state_r.timer0_overflow_flag;
               state_nxt.rdata[TCR_IE1] = state_r.irq1_request_flag;
               state_nxt.rdata[TCR_IT1] = state_r.irq1_type_select;
               state_nxt.rdata[TCR_IE0] = state_r.irq0_request_flag;
               state_nxt.rdata[TCR_IT0] = state_r.irq0_type_select;
            end
            ADDR_SERIAL_CONTROL: begin
               state_nxt.rdata[SCR_RX] = state_r.rx_done_flag;
               state_nxt.rdata[SCR_TX] = state_r.tx_done_flag;
            end
            ADDR_TIMER2_CONTROL: begin
               state_nxt.rdata[T2C_TF2] = state_r.timer2_overflow_flag;
               state_nxt.rdata[T2C_TIMER2_EXTERNAL_FLAG] = state_r.timer2_external_flag;
               state_nxt.rdata[T2C_TIMER2_EXTERNAL_ENABLE] = state_r.timer2_external_enable;
            end
            default: begin
               state_nxt.rdata = 8'h00;
            end
         endcase
      end
   end

   // State register; reset loads constants only.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '0;
         state_r.pin_meta <= RST_PIN_LEVEL;
         state_r.pin_sync <= RST_PIN_LEVEL;
         state_r.pin_prev <= RST_PIN_LEVEL;
         state_r.enable_mask <= RST_ENABLE_MASK;
         state_r.priority_sel <= RST_PRIORITY;
         state_r.vec <= VEC_BASE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign sfr_rdata = state_r.rdata;
   assign irq_req = state_r.req;
   assign irq_vector = state_r.vec;
   assign wake_req = state_r.wake;

endmodule : sic_ctrl

// ---- verif/sic_ctrl_props.sv ----
/*
 Checker for the port behaviour of sic_ctrl.
 Assumes it is bound to sic_ctrl and sees that module's ports only.
*/
module sic_ctrl_chk
   import sic_pkg::*;
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port.
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   // Core handshake.
   input wire logic mc_tick,
   input wire logic insn_boundary,
   input wire logic vec_ack,
   input wire logic irq_req,
   input wire logic [15:0] irq_vector
);
   timeunit 1ns;
   timeprecision 1ns;
   // Shadows of enable and priority, built from port writes alone.
   logic [7:0] iem_r;
   logic [5:0] pri_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // The shadows follow writes one edge later, exactly as the registers do.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         iem_r <= 8'h00;
         pri_r <= 6'h00;
      end else if (sfr_wr && sfr_addr == ADDR_ENABLE_MASK) begin
         iem_r <= sfr_wdata & 8'hbf;
      end else if (sfr_wr && sfr_addr == ADDR_PRIORITY) begin
         pri_r <= sfr_wdata[5:0];
      end
   end
   chk_ack_drops_req: assert property (vec_ack && irq_req |=> !irq_req)
      else $error("request stayed up after acknowledge");
   chk_req_holds: assert property (irq_req && !vec_ack |=> irq_req && $stable(irq_vector))
      else $error("request or vector changed before acknowledge");
   chk_global_gate: assert property (!iem_r[IEM_GLOBAL] && !irq_req |=> !irq_req)
      else $error("request raised with global enable clear");
   chk_vector_map: assert property (irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h002b)
      else $error("vector outside the table");
   chk_rise_boundary: assert property ($rose(irq_req) |-> $past(mc_tick && insn_boundary))
      else $error("request raised off a boundary tick");
   chk_idle_rdata: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
      else $error("read data not zero without a read");
   chk_enable_read: assert property (sfr_rd && sfr_addr == ADDR_ENABLE_MASK |=> sfr_rdata == $past(iem_r))
      else $error("enable register read wrong");
   chk_prio_read: assert property (sfr_rd && sfr_addr == ADDR_PRIORITY |=> sfr_rdata == {2'b00, $past(pri_r)})
      else $error("priority register read wrong");
   cov_vectored: cover property (vec_ack && irq_req);
   cov_raised: cover property ($rose(irq_req));
   cov_enable_read: cover property (sfr_rd && sfr_addr == ADDR_ENABLE_MASK);
endmodule : sic_ctrl_chk

bind sic_ctrl sic_ctrl_chk u_sic_ctrl_chk (.core_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
   .sfr_rdata, .mc_tick, .insn_boundary, .vec_ack, .irq_req, .irq_vector);

// ---- verif/sic_core_model.sv ----
/*
 Behavioural core: machine-cycle ticks, vectoring and service returns.
 Assumes the one-cycle pulse handshake of sic_ctrl on core_clk.
*/
module sic_core_model (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Controller side.
   input wire logic irq_req,
   input wire logic [15:0] irq_vector,
   output logic mc_tick,
   output logic insn_boundary,
   output logic vec_ack,
   output logic reti_done,
   // Testbench side.
   input wire logic slow,
   output logic [15:0] seen_vec,
   output logic [7:0] ack_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph_r;
   logic [3:0] wait_r;
   logic [5:0] svc_r;
   logic [2:0] depth_r;
   logic odd_r; // Toggles each machine cycle, so only every other tick is a boundary.
   // Acks only a standing request; a nested service restarts the countdown.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {ph_r, wait_r, svc_r, depth_r, odd_r, vec_ack, reti_done, mc_tick, insn_boundary} <= '0;
         seen_vec <= 16'h0000;
         ack_cnt <= 8'h00;
      end else begin
         ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
         mc_tick <= (ph_r == 2'h2);
         // Two-cycle instructions: half of the ticks fall inside one, so a post there is wrong.
         if (ph_r == 2'h2) begin
            odd_r <= ~odd_r;
         end
         insn_boundary <= odd_r;
         vec_ack <= 1'b0;
         reti_done <= 1'b0;
         if (irq_req && !vec_ack) begin
            wait_r <= wait_r + 4'h1;
            if (wait_r >= (slow ? 4'h9 : 4'h0)) begin
               vec_ack <= 1'b1;
               wait_r <= 4'h0;
               seen_vec <= irq_vector;
               ack_cnt <= ack_cnt + 8'h01;
               depth_r <= depth_r + 3'h1;
               svc_r <= 6'h28;
            end
         end else if (depth_r != 3'h0 && !vec_ack) begin
            svc_r <= svc_r - 6'h01;
            if (svc_r == 6'h01) begin
               reti_done <= 1'b1;
               depth_r <= depth_r - 3'h1;
               svc_r <= 6'h28;
            end
         end
      end
   end
endmodule : sic_core_model

// ---- verif/tb.sv ----
/*
 Self-checking bench for sic_ctrl with a behavioural core model.
 Assumes a 25 MHz core_clk and register access by strobe pulses.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import sic_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic pin0 = 1'b1, pin1 = 1'b1, pin2 = 1'b1, wr_s = 1'b0, rd_s = 1'b0, slow = 1'b0;
   logic [4:0] pul = 5'h00;
   logic [7:0] a = 8'h00, wd = 8'h00, rdat, ack_cnt, acks_seen = 8'h00;
   logic mc_tick, insn_boundary, vec_ack, reti_done, irq_req, wake_req;
   logic [15:0] irq_vector, seen_vec;
   int err_count = 0, checked = 0, retis = 0, r0;
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (reti_done === 1'b1) retis++;
   end
   sic_ctrl u_sic_ctrl (.core_clk, .rst_n, .ext_irq0_pin(pin0), .ext_irq1_pin(pin1), .timer2_trigger_pin(pin2),
      .timer0_overflow(pul[0]), .timer1_overflow(pul[1]), .timer2_overflow(pul[2]), .rx_done(pul[3]),
      .tx_done(pul[4]), .sfr_addr(a), .sfr_wr(wr_s), .sfr_wdata(wd), .sfr_rd(rd_s), .sfr_rdata(rdat),
      .mc_tick, .insn_boundary, .vec_ack, .reti_done, .irq_req, .irq_vector, .wake_req);
   sic_core_model u_sic_core_model (.core_clk, .rst_n, .irq_req, .irq_vector, .mc_tick, .insn_boundary,
      .vec_ack, .reti_done, .slow, .seen_vec, .ack_cnt);
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task automatic mis(input string m);
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
   endtask : mis
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) mis($sformatf("byte %h expected %h", g, e));
   endtask : chk8
   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) mis($sformatf("vector %h expected %h", g, e));
   endtask : chk16
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(negedge core_clk);
      a = ad;
      wd = d;
      wr_s = 1'b1;
      @(negedge core_clk);
      wr_s = 1'b0;
   endtask : wr
   // Read data stands for the one cycle after the strobe edge, so it is sampled there.
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      @(negedge core_clk);
      a = ad;
      rd_s = 1'b1;
      @(negedge core_clk);
      rd_s = 1'b0;
      chk8(rdat, e);
   endtask : rd
   task automatic pulse(input logic [4:0] p);
      @(negedge core_clk);
      pul = p;
      @(negedge core_clk);
      pul = 5'h00;
   endtask : pulse
   // Waits, bounded, for the next vectoring seen by the core model.
   task automatic vec(input logic [15:0] e);
      int n;
      n = 0;
      while (ack_cnt === acks_seen && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 400) begin
         mis("no vectoring");
         stop_test();
      end
      acks_seen = acks_seen + 8'h01;
      chk16(seen_vec, e);
   endtask : vec
   initial begin
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      chk16(irq_vector, VEC_BASE);
      rd(ADDR_ENABLE_MASK, RST_ENABLE_MASK);
      wr(ADDR_ENABLE_MASK, 8'h7f);
      rd(ADDR_ENABLE_MASK, 8'h3f);
      wr(ADDR_PRIORITY, 8'hff);
      rd(ADDR_PRIORITY, 8'h3f);
      wr(ADDR_PRIORITY, 8'h00);
      rd(8'h90, 8'h00);
      pulse(5'h03);
      repeat (20) @(negedge core_clk);
      chk8({7'h00, irq_req}, 8'h00);
      rd(ADDR_TIMER_CONTROL, 8'ha0);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      pulse(5'h01);
      wr(ADDR_ENABLE_MASK, 8'h82);
      vec(16'h000b);
      rd(ADDR_TIMER_CONTROL, 8'h00);
      // Four sources pending at once, answered slowly, come out in fixed order.
      slow = 1'b1;
      wr(ADDR_ENABLE_MASK, 8'h8f);
      wr(ADDR_TIMER_CONTROL, 8'haf);
      for (int i = 0; i < 4; i++) vec(VEC_BASE + 16'(i * 8));
      rd(ADDR_TIMER_CONTROL, 8'h05);
      slow = 1'b0;
      wr(ADDR_PRIORITY, 8'h04);
      wr(ADDR_TIMER_CONTROL, 8'h25);
      vec(16'h000b);
      r0 = retis;
      wr(ADDR_TIMER_CONTROL, 8'h0d);
      vec(16'h0013);
      chk8(8'(retis - r0), 8'h00);
      wr(ADDR_PRIORITY, 8'h00);
      wr(ADDR_ENABLE_MASK, 8'hb0);
      pulse(5'h18);
      vec(16'h0023);
      rd(ADDR_SERIAL_CONTROL, 8'h03);
      wr(ADDR_SERIAL_CONTROL, 8'h00);
      wr(ADDR_TIMER2_CONTROL, 8'h08);
      pin2 = 1'b0;
      vec(16'h002b);
      rd(ADDR_TIMER2_CONTROL, 8'h48);
      pin2 = 1'b1;
      wr(ADDR_TIMER2_CONTROL, 8'h08);
      pulse(5'h04);
      vec(16'h002b);
      rd(ADDR_TIMER2_CONTROL, 8'h88);
      wr(ADDR_TIMER2_CONTROL, 8'h00);
      // Level mode: the flag follows the pin and survives vectoring.
      wr(ADDR_TIMER_CONTROL, 8'h00);
      wr(ADDR_ENABLE_MASK, 8'h81);
      pin0 = 1'b0;
      vec(VEC_BASE);
      rd(ADDR_TIMER_CONTROL, 8'h02);
      chk8({7'h00, wake_req}, 8'h01);
      pin0 = 1'b1;
      repeat (3) @(negedge core_clk);
      rd(ADDR_TIMER_CONTROL, 8'h00);
      chk8({7'h00, wake_req}, 8'h00);
      wr(ADDR_TIMER_CONTROL, 8'h04);
      wr(ADDR_ENABLE_MASK, 8'h84);
      pin1 = 1'b0;
      vec(16'h0013);
      pin1 = 1'b1;
      rd(ADDR_TIMER_CONTROL, 8'h04);
      // A reset in mid-run, during a service, must bring back the reset values.
      @(negedge core_clk);
      rst_n = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      chk8({7'h00, irq_req}, 8'h00);
      chk16(irq_vector, VEC_BASE);
      rd(ADDR_ENABLE_MASK, RST_ENABLE_MASK);
      rd(ADDR_PRIORITY, {2'h0, RST_PRIORITY});
      stop_test();
   end
endmodule : tb
